// ### logic/hsfc_regs.vh
`ifndef HSFC_REGS_VH
`define HSFC_REGS_VH

// register offsets
`define HSFC_MAKER_LEN_OFS   8'h23
`define HSFC_PROD_LEN_OFS    8'h24
`define HSFC_MAKER_FIRST     8'h50
`define HSFC_MAKER_LAST      8'h8f
`define HSFC_PROD_FIRST      8'h90
`define HSFC_PROD_LAST       8'hcf
`define HSFC_FEATURE_OFS     8'hf0
`define HSFC_STATUS_OFS      8'hf8

// text storage
`define HSFC_TEXT_DEPTH      128
`define HSFC_TEXT_AW         7
`define HSFC_PROD_BASE       7'h40
`define HSFC_TEXT_MAX        7'h40
`define HSFC_LEN_W           7

// string descriptor indices
`define HSFC_MAKER_INDEX     8'h03
`define HSFC_PROD_INDEX      8'h02

// feature register fields
`define HSFC_FEAT_SPREAD     0
`define HSFC_FEAT_DLY_LO     1
`define HSFC_FEAT_DLY_HI     3
`define HSFC_FEAT_STS_EN     4
`define HSFC_FEAT_WMASK      8'h1f
`define HSFC_FEAT_RESET      8'h00

// status/command fields
`define HSFC_STS_CFG         0
`define HSFC_STS_SRST        1

// reset values
`define HSFC_BYTE_RESET      8'h00
`define HSFC_LEN_RESET       7'h00

// power re-enable timing
`define HSFC_DLY_UNIT_MS     200
`define HSFC_US_PER_MS       1000
`define HSFC_CLK_MHZ         100
`define HSFC_TICK_W          25
`define HSFC_DLY_W           3

`endif

// ### logic/hsfc_config_regs.v
`timescale 1ns/100ps
`include "hsfc_regs.vh"

module hsfc_config_regs #(
  parameter DLY_UNIT_CYCLES =
    `HSFC_DLY_UNIT_MS * `HSFC_US_PER_MS * `HSFC_CLK_MHZ
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       clk_en,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       desc_req,
  input  wire [7:0] desc_index,
  input  wire       desc_ready,
  output reg        desc_valid,
  output reg  [7:0] desc_byte,
  output reg        desc_last,
  output reg        desc_none,
  input  wire       high_speed_in,
  input  wire       high_speed_suspend_in,
  input  wire       super_speed_in,
  input  wire       super_speed_suspend_in,
  output reg        high_speed_indicator,
  output reg        high_speed_suspend_indicator,
  output reg        super_speed_indicator,
  output reg        super_speed_suspend_indicator,
  output reg        indicators_oe,
  input  wire [2:0] otp_power_delay,
  input  wire       charge_mode_change,
  output reg        port_power_switch_control,
  output reg        spread_spectrum_off,
  input  wire       config_mode_enter,
  output reg        upstream_connect_allow
);

  // ****************************************************************
  // storage
  // ****************************************************************
  localparam [31:0] TICK_LAST_FULL = DLY_UNIT_CYCLES - 1;
  localparam [`HSFC_TICK_W-1:0] TICK_LAST =
    TICK_LAST_FULL[`HSFC_TICK_W-1:0];

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg [7:0]              text_r [0:`HSFC_TEXT_DEPTH-1];
  reg [`HSFC_LEN_W-1:0]  maker_text_length_r;
  reg [`HSFC_LEN_W-1:0]  product_text_length_r;
  reg [7:0]              feature_r;
  reg                    interface_soft_reset_r;
  reg                    configuration_in_progress_r;
  reg                    state_r;
  reg [`HSFC_TEXT_AW-1:0] base_r;
  reg [`HSFC_LEN_W-1:0]  len_r;
  reg [`HSFC_LEN_W-1:0]  cnt_r;
  reg                    waiting_r;
  reg [`HSFC_TICK_W-1:0] tick_r;
  reg [`HSFC_DLY_W-1:0]  units_r;
  integer                i;

  wire                   clr_all;
  wire                   in_maker;
  wire                   in_prod;
  wire [`HSFC_TEXT_AW-1:0] text_idx;
  wire [7:0]             text_ofs;
  wire [`HSFC_LEN_W-1:0] wlen;
  wire [`HSFC_DLY_W-1:0] power_restore_delay;
  wire [`HSFC_DLY_W-1:0] eff_delay;
  wire                   status_pins_enable;
  wire                   wr_status;

  // ****************************************************************
  // decode
  // ****************************************************************
  // soft reset waits for the clock enable so a frozen block stays frozen
  assign clr_all  = sys_rst | (clk_en & interface_soft_reset_r);
  assign in_maker = (reg_addr >= `HSFC_MAKER_FIRST) &&
                    (reg_addr <= `HSFC_MAKER_LAST);
  assign in_prod  = (reg_addr >= `HSFC_PROD_FIRST) &&
                    (reg_addr <= `HSFC_PROD_LAST);
  // both arrays are contiguous so one subtraction indexes them
  assign text_ofs = reg_addr - `HSFC_MAKER_FIRST;
  assign text_idx = text_ofs[`HSFC_TEXT_AW-1:0];
  // length writes whose low seven bits exceed the maximum are held at the maximum
  assign wlen = (reg_wdata[`HSFC_LEN_W-1:0] > `HSFC_TEXT_MAX) ?
                `HSFC_TEXT_MAX : reg_wdata[`HSFC_LEN_W-1:0];
  assign power_restore_delay =
    feature_r[`HSFC_FEAT_DLY_HI:`HSFC_FEAT_DLY_LO];
  // one-time field wins unless it is all zeros
  assign eff_delay = (otp_power_delay == 3'h0) ?
                     power_restore_delay : otp_power_delay;
  assign status_pins_enable = feature_r[`HSFC_FEAT_STS_EN];
  assign wr_status = reg_wr && (reg_addr == `HSFC_STATUS_OFS);

  // ****************************************************************
  // register writes
  // ****************************************************************
  // text, length and feature registers, reloaded by soft reset
  always @(posedge mclk) begin
    if (clr_all) begin
      for (i = 0; i < `HSFC_TEXT_DEPTH; i = i + 1) begin
        text_r[i] <= `HSFC_BYTE_RESET;
      end
      maker_text_length_r   <= `HSFC_LEN_RESET;
      product_text_length_r <= `HSFC_LEN_RESET;
      feature_r             <= `HSFC_FEAT_RESET;
    end else if (clk_en && reg_wr) begin
      if (in_maker || in_prod) begin
        text_r[text_idx] <= reg_wdata;
      end
      if (reg_addr == `HSFC_MAKER_LEN_OFS) begin
        maker_text_length_r <= wlen;
      end
      if (reg_addr == `HSFC_PROD_LEN_OFS) begin
        product_text_length_r <= wlen;
      end
      if (reg_addr == `HSFC_FEATURE_OFS) begin
        // reserved bits stay zero
        feature_r <= reg_wdata & `HSFC_FEAT_WMASK;
      end
    end
  end

  // soft reset bit: set by writing 1, cleared after one reset cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      interface_soft_reset_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_status && reg_wdata[`HSFC_STS_SRST]) begin
        interface_soft_reset_r <= 1'b1;
      end else if (interface_soft_reset_r) begin
        interface_soft_reset_r <= 1'b0;
      end
    end
  end

  // configuration flag: hardware set wins over a write-1 clear
  always @(posedge mclk) begin
    if (sys_rst) begin
      configuration_in_progress_r <= 1'b0;
    end else if (clk_en) begin
      if (config_mode_enter) begin
        configuration_in_progress_r <= 1'b1;
      end else if (wr_status && reg_wdata[`HSFC_STS_CFG]) begin
        configuration_in_progress_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  // read data registered one cycle after the strobe
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      if (in_maker || in_prod) begin
        reg_rdata <= text_r[text_idx];
      end else if (reg_addr == `HSFC_MAKER_LEN_OFS) begin
        reg_rdata <= {1'b0, maker_text_length_r};
      end else if (reg_addr == `HSFC_PROD_LEN_OFS) begin
        reg_rdata <= {1'b0, product_text_length_r};
      end else if (reg_addr == `HSFC_FEATURE_OFS) begin
        reg_rdata <= feature_r & `HSFC_FEAT_WMASK;
      end else if (reg_addr == `HSFC_STATUS_OFS) begin
        reg_rdata <= {6'h00, interface_soft_reset_r,
                      configuration_in_progress_r};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // string descriptor streaming
  // ****************************************************************
  // one byte per accepted beat, exactly len bytes per request
  always @(posedge mclk) begin
    if (clr_all) begin
      state_r    <= ST_IDLE;
      base_r     <= {`HSFC_TEXT_AW{1'b0}};
      len_r      <= `HSFC_LEN_RESET;
      cnt_r      <= `HSFC_LEN_RESET;
      desc_valid <= 1'b0;
      desc_byte  <= 8'h00;
      desc_last  <= 1'b0;
      desc_none  <= 1'b0;
    end else if (clk_en) begin
      desc_none <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (desc_req) begin
            if (desc_index == `HSFC_MAKER_INDEX &&
                maker_text_length_r != `HSFC_LEN_RESET) begin
              state_r    <= ST_SEND;
              base_r     <= {`HSFC_TEXT_AW{1'b0}};
              len_r      <= maker_text_length_r;
              cnt_r      <= {{(`HSFC_LEN_W-1){1'b0}}, 1'b1};
              desc_valid <= 1'b1;
              desc_byte  <= text_r[0];
              desc_last  <= (maker_text_length_r ==
                             {{(`HSFC_LEN_W-1){1'b0}}, 1'b1});
            end else if (desc_index == `HSFC_PROD_INDEX &&
                product_text_length_r != `HSFC_LEN_RESET) begin
              state_r    <= ST_SEND;
              base_r     <= `HSFC_PROD_BASE;
              len_r      <= product_text_length_r;
              cnt_r      <= {{(`HSFC_LEN_W-1){1'b0}}, 1'b1};
              desc_valid <= 1'b1;
              desc_byte  <= text_r[`HSFC_PROD_BASE];
              desc_last  <= (product_text_length_r ==
                             {{(`HSFC_LEN_W-1){1'b0}}, 1'b1});
            end else begin
              desc_none <= 1'b1;
            end
          end
        end
        ST_SEND: begin
          if (desc_ready) begin
            if (cnt_r == len_r) begin
              state_r    <= ST_IDLE;
              desc_valid <= 1'b0;
              desc_last  <= 1'b0;
            end else begin
              desc_byte <= text_r[base_r + cnt_r[`HSFC_TEXT_AW-1:0]];
              desc_last <= (cnt_r + 7'h01 == len_r);
              cnt_r     <= cnt_r + 7'h01;
            end
          end
        end
        default: begin
          state_r    <= ST_IDLE;
          desc_valid <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // power re-enable interval
  // ****************************************************************
  // drop power control, wait (delay + 1) units, restore it
  always @(posedge mclk) begin
    if (clr_all) begin
      waiting_r                 <= 1'b0;
      tick_r                    <= {`HSFC_TICK_W{1'b0}};
      units_r                   <= {`HSFC_DLY_W{1'b0}};
      port_power_switch_control <= 1'b1;
    end else if (clk_en) begin
      if (charge_mode_change) begin
        waiting_r                 <= 1'b1;
        tick_r                    <= {`HSFC_TICK_W{1'b0}};
        units_r                   <= eff_delay;
        port_power_switch_control <= 1'b0;
      end else if (waiting_r) begin
        if (tick_r != TICK_LAST) begin
          tick_r <= tick_r + 25'h0000001;
        end else begin
          tick_r <= {`HSFC_TICK_W{1'b0}};
          if (units_r == {`HSFC_DLY_W{1'b0}}) begin
            waiting_r                 <= 1'b0;
            port_power_switch_control <= 1'b1;
          end else begin
            units_r <= units_r - 3'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // status indicators and misc outputs
  // ****************************************************************
  // indicators are registered; enable floats them when low
  always @(posedge mclk) begin
    if (clr_all) begin
      high_speed_indicator          <= 1'b0;
      high_speed_suspend_indicator  <= 1'b0;
      super_speed_indicator         <= 1'b0;
      super_speed_suspend_indicator <= 1'b0;
      indicators_oe                 <= 1'b0;
      spread_spectrum_off           <= 1'b0;
    end else if (clk_en) begin
      high_speed_indicator          <= high_speed_in;
      high_speed_suspend_indicator  <= high_speed_suspend_in;
      super_speed_indicator         <= super_speed_in;
      super_speed_suspend_indicator <= super_speed_suspend_in;
      indicators_oe                 <= status_pins_enable;
      spread_spectrum_off <= feature_r[`HSFC_FEAT_SPREAD];
    end
  end

  // upstream connect held off while configuring
  always @(posedge mclk) begin
    if (sys_rst) begin
      upstream_connect_allow <= 1'b0;
    end else if (clk_en) begin
      upstream_connect_allow <= ~configuration_in_progress_r &
                                ~config_mode_enter;
    end
  end

endmodule

// ### verification/hsfc_config_regs_properties.sv
`timescale 1ns/100ps
`include "hsfc_regs.vh"
// ******
// port checks of the config register slice
// ******
module hsfc_config_checks (
  input wire       mclk,
  input wire       sys_rst,
  input wire       clk_en,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       desc_req,
  input wire [7:0] desc_index,
  input wire       desc_ready,
  input wire       desc_valid,
  input wire [7:0] desc_byte,
  input wire       desc_none,
  input wire       indicators_oe,
  input wire       charge_mode_change,
  input wire       port_power_switch_control,
  input wire       spread_spectrum_off,
  input wire       config_mode_enter,
  input wire       upstream_connect_allow
);
  reg  [7:0] feat_seen_r;
  wire       wr_feat = clk_en && reg_wr && reg_addr == `HSFC_FEATURE_OFS;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // remember the last feature write
  always @(posedge mclk) begin
    if (wr_feat)
      feat_seen_r <= reg_wdata;
  end
  property p_rsvd_zero;
    clk_en && reg_rd && reg_addr == `HSFC_FEATURE_OFS
      |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("feature reserved bits read nonzero");
  property p_spread;
    wr_feat |=> ##1 spread_spectrum_off == feat_seen_r[0];
  endproperty
  a_spread: assert property (p_spread)
    else $error("spread control not following feature bit");
  property p_oe;
    wr_feat |=> ##1 indicators_oe == feat_seen_r[4];
  endproperty
  a_oe: assert property (p_oe)
    else $error("indicator enable not following feature bit");
  property p_pwr_drop;
    clk_en && charge_mode_change |=> !port_power_switch_control;
  endproperty
  a_pwr_drop: assert property (p_pwr_drop)
    else $error("power switch not dropped");
  property p_pwr_hold;
    $fell(port_power_switch_control) |-> !port_power_switch_control [*8];
  endproperty
  a_pwr_hold: assert property (p_pwr_hold)
    else $error("power switch restored too early");
  property p_cfg_block;
    clk_en && config_mode_enter |=> !upstream_connect_allow;
  endproperty
  a_cfg_block: assert property (p_cfg_block)
    else $error("upstream connect allowed while configuring");
  property p_no_string;
    clk_en && desc_req && !desc_valid && desc_index != `HSFC_MAKER_INDEX
      && desc_index != `HSFC_PROD_INDEX |=> desc_none;
  endproperty
  a_no_string: assert property (p_no_string)
    else $error("unknown index not refused");
  property p_byte_stands;
    clk_en && desc_valid && !desc_ready |=> desc_valid && $stable(desc_byte);
  endproperty
  a_byte_stands: assert property (p_byte_stands)
    else $error("descriptor byte changed before accept");
endmodule
bind hsfc_config_regs hsfc_config_checks u_hsfc_config_checks (
  .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .desc_req, .desc_index, .desc_ready, .desc_valid, .desc_byte,
  .desc_none, .indicators_oe, .charge_mode_change,
  .port_power_switch_control, .spread_spectrum_off, .config_mode_enter,
  .upstream_connect_allow
);

// ### verification/hsfc_loader.sv
`timescale 1ns/100ps
// ******
// eeprom or smbus host loading registers
// ******
module hsfc_loader (
  input  wire       mclk,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata
);
  // idle bus shows inverted values so stale data never looks valid
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task write_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  task read_reg(input [7:0] a, output [7:0] d);
    begin
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
    end
  endtask
  // text goes in as code units, low byte first
  task put_unit(input [7:0] a, input [15:0] u);
    begin
      write_reg(a, u[7:0]);
      write_reg(a + 8'h01, u[15:8]);
    end
  endtask
endmodule

// ### verification/test_hsfc_config_regs.sv
`timescale 1ns/100ps
`include "hsfc_regs.vh"
// ******
// bench for the config register slice
// ******
module test_hsfc_config_regs;
  reg        mclk, sys_rst, clk_en, desc_req, desc_ready;
  reg        high_speed_in, high_speed_suspend_in, super_speed_in;
  reg        super_speed_suspend_in, charge_mode_change, config_mode_enter;
  reg  [7:0] desc_index, seed, v;
  reg  [7:0] mem [0:127];
  reg  [2:0] otp_power_delay;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, desc_byte;
  wire       reg_wr, reg_rd, desc_valid, desc_last, desc_none, indicators_oe;
  wire       high_speed_indicator, high_speed_suspend_indicator;
  wire       super_speed_indicator, super_speed_suspend_indicator;
  wire       port_power_switch_control, spread_spectrum_off;
  wire       upstream_connect_allow;
  integer    fails, tests_run, i, n, t;
  localparam integer UNIT = 10;
  hsfc_config_regs #(.DLY_UNIT_CYCLES(UNIT)) u_hsfc_config_regs (
    .mclk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .desc_req, .desc_index, .desc_ready, .desc_valid,
    .desc_byte, .desc_last, .desc_none, .high_speed_in,
    .high_speed_suspend_in, .super_speed_in, .super_speed_suspend_in,
    .high_speed_indicator, .high_speed_suspend_indicator,
    .super_speed_indicator, .super_speed_suspend_indicator, .indicators_oe,
    .otp_power_delay, .charge_mode_change, .port_power_switch_control,
    .spread_spectrum_off, .config_mode_enter, .upstream_connect_allow);
  hsfc_loader u_hsfc_loader (.mclk, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata);
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // feature readback keeps only the writable low five bits
  function [7:0] exp_feat(input [7:0] d);
    exp_feat = {3'h0, d[4:0]};
  endfunction
  // power-off span: one-time field wins unless zero, plus one unit
  function integer exp_wait(input [2:0] otp, input [2:0] fd);
    exp_wait = ((otp != 3'h0 ? otp : fd) + 1) * UNIT;
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      u_hsfc_loader.read_reg(a, v);
      check(v, exp);
    end
  endtask
  // request a string and take it with random stalls
  task get_desc(input [7:0] idx, input [6:0] base, input [6:0] len);
    begin
      @(negedge mclk);
      desc_req = 1'b1;
      desc_index = idx;
      @(negedge mclk);
      desc_req = 1'b0;
      n = 0;
      check({7'h0, desc_none}, {7'h0, len == 7'h0});
      for (t = 0; t < 400 && n < len; t = t + 1) begin
        check({7'h0, desc_valid}, 8'h01);
        check(desc_byte, mem[base + n]);
        check({7'h0, desc_last}, {7'h0, n == len - 1});
        seed = lfsr(seed);
        desc_ready = seed[0];
        n = n + seed[0];
        @(negedge mclk);
      end
      desc_ready = 1'b0;
      check({7'h0, desc_valid}, 8'h00);
      check(n[7:0], {1'b0, len});
    end
  endtask
  task report_and_stop;
    begin
      if (fails == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // free running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // watchdog set well beyond the several hundred cycles the run needs
  initial begin
    #200000;
    fails = fails + 1;
    report_and_stop;
  end
  // main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    seed = 8'h26;
    {sys_rst, clk_en, desc_req, desc_ready, desc_index} = 12'hc00;
    {high_speed_in, high_speed_suspend_in, super_speed_in} = 3'h0;
    {super_speed_suspend_in, charge_mode_change, config_mode_enter} = 3'h0;
    otp_power_delay = 3'h0;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    check({7'h0, port_power_switch_control}, 8'h01);
    rd(`HSFC_FEATURE_OFS, 8'h00);
    rd(`HSFC_PROD_LEN_OFS, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      u_hsfc_loader.write_reg(`HSFC_FEATURE_OFS, seed);
      rd(`HSFC_FEATURE_OFS, exp_feat(seed));
      check({7'h0, spread_spectrum_off}, {7'h0, seed[0]});
      check({7'h0, indicators_oe}, {7'h0, seed[4]});
    end
    u_hsfc_loader.write_reg(`HSFC_FEATURE_OFS, 8'h16);
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      {high_speed_in, high_speed_suspend_in} = seed[3:2];
      {super_speed_in, super_speed_suspend_in} = seed[1:0];
      @(negedge mclk);
      check({4'h0, high_speed_indicator, high_speed_suspend_indicator,
        super_speed_indicator, super_speed_suspend_indicator},
        {4'h0, seed[3:0]});
    end
    for (i = 0; i < 128; i = i + 2) begin
      seed = lfsr(seed);
      mem[i] = seed;
      mem[i + 1] = ~seed;
      u_hsfc_loader.put_unit(`HSFC_MAKER_FIRST + i, {~seed, seed});
    end
    u_hsfc_loader.write_reg(`HSFC_MAKER_LEN_OFS, 8'h7f);
    rd(`HSFC_MAKER_LEN_OFS, 8'h40);
    get_desc(`HSFC_MAKER_INDEX, 7'h00, 7'h40);
    u_hsfc_loader.write_reg(`HSFC_PROD_LEN_OFS, {3'h0, seed[4:0]} + 8'h01);
    get_desc(`HSFC_PROD_INDEX, 7'h40, {2'h0, seed[4:0]} + 7'h01);
    u_hsfc_loader.write_reg(`HSFC_MAKER_LEN_OFS, 8'h00);
    get_desc(`HSFC_MAKER_INDEX, 7'h00, 7'h00);
    get_desc(8'h05, 7'h00, 7'h00);
    for (i = 0; i < 2; i = i + 1) begin
      otp_power_delay = i ? 3'h1 : 3'h0;
      @(negedge mclk);
      charge_mode_change = 1'b1;
      @(negedge mclk);
      charge_mode_change = 1'b0;
      check({7'h0, port_power_switch_control}, 8'h00);
      n = 0;
      while (port_power_switch_control === 1'b0 && n < 300) begin
        @(negedge mclk);
        n = n + 1;
      end
      t = exp_wait(otp_power_delay, 3'h3);
      check({7'h0, n >= t && n <= t + 1}, 8'h01);
    end
    // a write while the clock enable is low must be dropped
    clk_en = 1'b0;
    u_hsfc_loader.write_reg(`HSFC_FEATURE_OFS, 8'h01);
    clk_en = 1'b1;
    rd(`HSFC_FEATURE_OFS, exp_feat(8'h16));
    @(negedge mclk);
    config_mode_enter = 1'b1;
    @(negedge mclk);
    config_mode_enter = 1'b0;
    check({7'h0, upstream_connect_allow}, 8'h00);
    rd(`HSFC_STATUS_OFS, 8'h01);
    u_hsfc_loader.write_reg(`HSFC_STATUS_OFS, 8'h01);
    @(negedge mclk);
    check({7'h0, upstream_connect_allow}, 8'h01);
    u_hsfc_loader.write_reg(`HSFC_STATUS_OFS, 8'h02);
    rd(`HSFC_FEATURE_OFS, 8'h00);
    rd(`HSFC_PROD_LEN_OFS, 8'h00);
    rd(`HSFC_STATUS_OFS, 8'h00);
    rd(8'he0, 8'h00);
    report_and_stop;
  end
endmodule
